// File: rtl/ipcr_pkg.sv
// Package: register map, field layout and source tables of the priority configuration block
package ipcr_pkg;

    // Register bus geometry
    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 16;
    localparam int NUM_REGS = 4;
    localparam int NUM_SRC  = 19;
    localparam int SRC_W    = 5;
    localparam int LEVEL_W  = 2;
    localparam int NUM_LVL  = 4;

    // Register offsets, in bus words
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CFG_DEBUG_A      = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CFG_DEBUG_B      = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CFG_FLASH_SYSTEM = 5'h02;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_CFG_PORTS_CAN    = 5'h03;

    // Register indices inside the block
    localparam logic [1:0] IDX_DEBUG_A      = 2'h0;
    localparam logic [1:0] IDX_DEBUG_B      = 2'h1;
    localparam logic [1:0] IDX_FLASH_SYSTEM = 2'h2;
    localparam logic [1:0] IDX_PORTS_CAN    = 2'h3;

    // Writable bits of each register; all other bits are reserved
    localparam logic [DATA_W-1:0] MASK_DEBUG_A      = 16'h3c00;
    localparam logic [DATA_W-1:0] MASK_DEBUG_B      = 16'h003f;
    localparam logic [DATA_W-1:0] MASK_FLASH_SYSTEM = 16'hffcf;
    localparam logic [DATA_W-1:0] MASK_PORTS_CAN    = 16'hfffc;

    // Reset value of every priority register
    localparam logic [DATA_W-1:0] RESET_PRIORITY_CFG = 16'h0000;

    // Field positions (low bit of each 2-bit field)
    localparam int DEBUG_BREAKPOINT_LEVEL_LSB     = 12;
    localparam int DEBUG_STEP_COUNTER_LEVEL_LSB   = 10;
    localparam int DEBUG_RECEIVE_FULL_LEVEL_LSB   = 4;
    localparam int DEBUG_TRANSMIT_EMPTY_LEVEL_LSB = 2;
    localparam int TRACE_BUFFER_LEVEL_LSB         = 0;
    localparam int FLASH_BUFFERS_EMPTY_LEVEL_LSB  = 14;
    localparam int FLASH_CMD_COMPLETE_LEVEL_LSB   = 12;
    localparam int FLASH_ERROR_LEVEL_LSB          = 10;
    localparam int PLL_LOSS_LEVEL_LSB             = 8;
    localparam int LOW_VOLTAGE_LEVEL_LSB          = 6;
    localparam int EXT_LINE_B_LEVEL_LSB           = 2;
    localparam int EXT_LINE_A_LEVEL_LSB           = 0;
    localparam int PORT_D_LEVEL_LSB               = 14;
    localparam int PORT_E_LEVEL_LSB               = 12;
    localparam int PORT_F_LEVEL_LSB               = 10;
    localparam int CAN_MSG_BUFFER_LEVEL_LSB       = 8;
    localparam int CAN_WAKEUP_LEVEL_LSB           = 6;
    localparam int CAN_ERROR_LEVEL_LSB            = 4;
    localparam int CAN_BUS_OFF_LEVEL_LSB          = 2;

    // Per source: register holding its field, in source-number order
    localparam logic [1:0] SRC_REG [NUM_SRC] = '{
        IDX_DEBUG_A, IDX_DEBUG_A,
        IDX_DEBUG_B, IDX_DEBUG_B, IDX_DEBUG_B,
        IDX_FLASH_SYSTEM, IDX_FLASH_SYSTEM, IDX_FLASH_SYSTEM, IDX_FLASH_SYSTEM,
        IDX_FLASH_SYSTEM, IDX_FLASH_SYSTEM, IDX_FLASH_SYSTEM,
        IDX_PORTS_CAN, IDX_PORTS_CAN, IDX_PORTS_CAN, IDX_PORTS_CAN,
        IDX_PORTS_CAN, IDX_PORTS_CAN, IDX_PORTS_CAN};

    // Per source: low bit of its field
    localparam int SRC_LSB [NUM_SRC] = '{
        DEBUG_BREAKPOINT_LEVEL_LSB, DEBUG_STEP_COUNTER_LEVEL_LSB,
        DEBUG_RECEIVE_FULL_LEVEL_LSB, DEBUG_TRANSMIT_EMPTY_LEVEL_LSB, TRACE_BUFFER_LEVEL_LSB,
        FLASH_BUFFERS_EMPTY_LEVEL_LSB, FLASH_CMD_COMPLETE_LEVEL_LSB, FLASH_ERROR_LEVEL_LSB,
        PLL_LOSS_LEVEL_LSB, LOW_VOLTAGE_LEVEL_LSB, EXT_LINE_B_LEVEL_LSB, EXT_LINE_A_LEVEL_LSB,
        PORT_D_LEVEL_LSB, PORT_E_LEVEL_LSB, PORT_F_LEVEL_LSB, CAN_MSG_BUFFER_LEVEL_LSB,
        CAN_WAKEUP_LEVEL_LSB, CAN_ERROR_LEVEL_LSB, CAN_BUS_OFF_LEVEL_LSB};

    // Sources whose field maps to levels 1..3 (debug unit); bit i is source i
    localparam logic [NUM_SRC-1:0] SRC_DEBUG_CLASS = 19'h0001f;

    // Register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ipcr_bus_req_t;

    // Register bus answer
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } ipcr_bus_rsp_t;

endpackage

// File: rtl/ipcr_top.sv
// Top: priority configuration registers, level decode and same-level encoder
`timescale 1ns/1ns
module ipcr_top (
    // Clock and reset
    input  wire logic                                            ref_clk,
    input  wire logic                                            rst,
    // Peripheral register bus
    input  wire ipcr_pkg::ipcr_bus_req_t                         bus_req,
    output ipcr_pkg::ipcr_bus_rsp_t                              bus_rsp,
    // Interrupt request lines, one per source
    input  wire logic [ipcr_pkg::NUM_SRC-1:0]                    irq_req,
    // Decoded configuration per source
    output logic      [ipcr_pkg::NUM_SRC-1:0]                    src_enabled,
    output logic      [ipcr_pkg::NUM_SRC-1:0][ipcr_pkg::LEVEL_W-1:0] src_level,
    // Per-level winner towards the core
    output logic      [ipcr_pkg::NUM_LVL-1:0]                    level_pending,
    output logic      [ipcr_pkg::NUM_LVL-1:0][ipcr_pkg::SRC_W-1:0]   level_winner
);

    // Stored priority registers
    logic [ipcr_pkg::DATA_W-1:0] cfg [ipcr_pkg::NUM_REGS];

    // Address decode
    wire logic                        hit_debug_a;
    wire logic                        hit_debug_b;
    wire logic                        hit_flash_system;
    wire logic                        hit_ports_can;
    wire logic                        addr_hit;
    wire logic [1:0]                  addr_idx;
    wire logic [ipcr_pkg::DATA_W-1:0] write_mask;
    wire logic [ipcr_pkg::DATA_W-1:0] next_rdata;

    assign hit_debug_a      = bus_req.addr == ipcr_pkg::OFS_PRIORITY_CFG_DEBUG_A;
    assign hit_debug_b      = bus_req.addr == ipcr_pkg::OFS_PRIORITY_CFG_DEBUG_B;
    assign hit_flash_system = bus_req.addr == ipcr_pkg::OFS_PRIORITY_CFG_FLASH_SYSTEM;
    assign hit_ports_can    = bus_req.addr == ipcr_pkg::OFS_PRIORITY_CFG_PORTS_CAN;
    assign addr_hit = hit_debug_a | hit_debug_b | hit_flash_system | hit_ports_can;

    // Register index and writable-bit mask of the addressed register
    assign addr_idx = hit_debug_a      ? ipcr_pkg::IDX_DEBUG_A :
                      hit_debug_b      ? ipcr_pkg::IDX_DEBUG_B :
                      hit_flash_system ? ipcr_pkg::IDX_FLASH_SYSTEM :
                                         ipcr_pkg::IDX_PORTS_CAN;
    assign write_mask = hit_debug_a      ? ipcr_pkg::MASK_DEBUG_A :
                        hit_debug_b      ? ipcr_pkg::MASK_DEBUG_B :
                        hit_flash_system ? ipcr_pkg::MASK_FLASH_SYSTEM :
                                           ipcr_pkg::MASK_PORTS_CAN;

    // Unmapped reads answer zero; reserved bits are never stored, so read zero
    assign next_rdata = addr_hit ? cfg[addr_idx] : ipcr_pkg::RESET_PRIORITY_CFG;

    // Register write; reserved positions are masked off
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int r = 0; r < ipcr_pkg::NUM_REGS; r++) begin
                cfg[r] <= ipcr_pkg::RESET_PRIORITY_CFG;
            end
        end else if (bus_req.wr && addr_hit) begin
            cfg[addr_idx] <= bus_req.wdata & write_mask;
        end
    end

    // Read answer, one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp.valid <= bus_req.rd;
            bus_rsp.rdata <= bus_req.rd ? next_rdata : ipcr_pkg::RESET_PRIORITY_CFG;
        end
    end

    // Field extraction and level decode per source
    logic [ipcr_pkg::NUM_SRC-1:0]                        next_enabled;
    logic [ipcr_pkg::NUM_SRC-1:0][ipcr_pkg::LEVEL_W-1:0] next_level;

    for (genvar i = 0; i < ipcr_pkg::NUM_SRC; i++) begin : g_src
        wire logic [ipcr_pkg::LEVEL_W-1:0] field;
        assign field = cfg[ipcr_pkg::SRC_REG[i]][ipcr_pkg::SRC_LSB[i] +: ipcr_pkg::LEVEL_W];
        assign next_enabled[i] = |field;
        // Debug sources take the field as level; others take field minus one
        assign next_level[i] = (field == 2'h0) ? 2'h0 :
                               ipcr_pkg::SRC_DEBUG_CLASS[i] ? field :
                               ipcr_pkg::LEVEL_W'(field - 2'h1);
    end

    // Registered per-source configuration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_enabled <= '0;
            src_level   <= '0;
        end else begin
            src_enabled <= next_enabled;
            src_level   <= next_level;
        end
    end

    // Same-level encoder: scan downward so the lowest number is kept last
    logic [ipcr_pkg::NUM_LVL-1:0]                      next_pending;
    logic [ipcr_pkg::NUM_LVL-1:0][ipcr_pkg::SRC_W-1:0] next_winner;

    always_comb begin
        next_pending = '0;
        next_winner  = '0;
        for (int l = 0; l < ipcr_pkg::NUM_LVL; l++) begin
            for (int s = ipcr_pkg::NUM_SRC - 1; s >= 0; s--) begin
                if (irq_req[s] && src_enabled[s] &&
                    src_level[s] == ipcr_pkg::LEVEL_W'(l)) begin
                    next_pending[l] = 1'b1;
                    next_winner[l]  = ipcr_pkg::SRC_W'(s);
                end
            end
        end
    end

    // Registered encoder result
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            level_pending <= '0;
            level_winner  <= '0;
        end else begin
            level_pending <= next_pending;
            level_winner  <= next_winner;
        end
    end

endmodule

// File: verification/ipcr_irq_src.sv
// Request source model: drives the level request lines after a chosen lag
`timescale 1ns/1ns
module ipcr_irq_src (
    // Clock
    input  wire logic                         ref_clk,
    // Wanted pattern and lag in cycles
    input  wire logic [ipcr_pkg::NUM_SRC-1:0] want,
    input  wire logic [31:0]                  lag,
    // Request lines into the block
    output logic      [ipcr_pkg::NUM_SRC-1:0] irq_req
);
    int cnt = 0;
    initial irq_req = '0;
    // Follow the pattern after lag cycles, then hold it as a steady level
    always @(posedge ref_clk) begin
        if (want === irq_req) cnt <= 0;
        else if (cnt >= lag) begin
            irq_req <= want;
            cnt <= 0;
        end else cnt <= cnt + 1;
    end
endmodule

// File: verification/ipcr_top_assertions.sv
// Checker: bus answer, reset, decode and encoder relations
`timescale 1ns/1ns
module ipcr_checker (
    // Clock, reset and bus
    input wire logic                                        ref_clk,
    input wire logic                                        rst,
    input wire ipcr_pkg::ipcr_bus_req_t                     bus_req,
    input wire ipcr_pkg::ipcr_bus_rsp_t                     bus_rsp,
    // Requests and decoded outputs
    input wire logic [ipcr_pkg::NUM_SRC-1:0]                irq_req,
    input wire logic [ipcr_pkg::NUM_SRC-1:0]                src_enabled,
    input wire logic [ipcr_pkg::NUM_SRC-1:0][1:0]           src_level,
    input wire logic [ipcr_pkg::NUM_LVL-1:0]                level_pending,
    input wire logic [ipcr_pkg::NUM_LVL-1:0][4:0]           level_winner
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    read_answer_a: assert property (bus_req.rd |=> bus_rsp.valid)
        else $error("read without answer");
    idle_quiet_a: assert property (!bus_req.rd |=> !bus_rsp.valid && bus_rsp.rdata == 16'h0000)
        else $error("answer without read");
    reset_clear_a: assert property (disable iff (1'b0) rst |=> src_enabled == '0 && level_pending == '0)
        else $error("state not cleared by reset");
    debug_reserved_a: assert property (bus_req.rd && bus_req.addr == 5'h00 |=> (bus_rsp.rdata & 16'hc3ff) == 16'h0000)
        else $error("reserved bits of first register set");
    flash_reserved_a: assert property (bus_req.rd && bus_req.addr == 5'h02 |=> bus_rsp.rdata[5:4] == 2'h0)
        else $error("reserved bits of third register set");
    debug_nonzero_a: assert property (src_enabled[0] |-> src_level[0] != 2'h0)
        else $error("debug source at level 0");
    line_a_decode_a: assert property (bus_req.wr && bus_req.addr == 5'h02 && bus_req.wdata[1:0] == 2'h1 |=> ##1 src_enabled[11] && src_level[11] == 2'h0)
        else $error("line A field not decoded");
    pending_cause_a: assert property (level_pending != '0 |-> $past(irq_req & src_enabled) != '0)
        else $error("pending without enabled request");
    cover property (level_pending[2]);
    cover property (bus_req.wr && bus_req.addr == 5'h03);
    cover property (bus_rsp.valid && bus_rsp.rdata != 16'h0000);
endmodule
bind ipcr_top ipcr_checker chk (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .irq_req(irq_req), .src_enabled(src_enabled), .src_level(src_level),
    .level_pending(level_pending), .level_winner(level_winner));

// File: verification/tb_top.sv
// Testbench: register rows, decode, same-level encoder and reset
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic [4:0] a; logic [15:0] wd, rd; int s; logic [1:0] lv;} ipcr_row_t;
    ipcr_row_t rows [8] = '{'{5'h00, 16'hffff, 16'h3c00, 0, 2'h3},
        '{5'h00, 16'h1400, 16'h1400, 1, 2'h1}, '{5'h01, 16'hffe6, 16'h0026, 2, 2'h2},
        '{5'h02, 16'hffff, 16'hffcf, 5, 2'h2}, '{5'h02, 16'h1235, 16'h1205, 8, 2'h1},
        '{5'h02, 16'h000f, 16'h000f, 10, 2'h2}, '{5'h03, 16'h8103, 16'h8100, 12, 2'h1},
        '{5'h03, 16'h00c0, 16'h00c0, 16, 2'h2}};
    logic                    ref_clk = 1'b0;
    logic                    rst = 1'b1;
    ipcr_pkg::ipcr_bus_req_t bus_req = '0;
    ipcr_pkg::ipcr_bus_rsp_t bus_rsp;
    logic [18:0]             want = '0;
    int                      lag = 0;
    logic [18:0]             irq_req, src_enabled;
    logic [18:0][1:0]        src_level;
    logic [3:0]              level_pending;
    logic [3:0][4:0]         level_winner;
    int                      num_errors = 0;
    int                      samples_checked = 0;
    int                      cycles = 0;
    ipcr_top dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .irq_req(irq_req), .src_enabled(src_enabled), .src_level(src_level),
        .level_pending(level_pending), .level_winner(level_winner));
    ipcr_irq_src srcs (.ref_clk(ref_clk), .want(want), .lag(lag), .irq_req(irq_req));
    // Clock and hang guard
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(logic [4:0] a, logic [15:0] d);
        @(negedge ref_clk);
        bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        bus_req.wr = 1'b0;
    endtask
    task automatic bus_rd(logic [4:0] a, logic [15:0] exp);
        @(negedge ref_clk);
        bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge ref_clk);
        bus_req.rd = 1'b0;
        check("read valid", 16'h0001, {15'h0, bus_rsp.valid});
        check("read data", exp, bus_rsp.rdata);
    endtask
    task automatic lvl_case(logic [18:0] w, int l, logic [3:0] pend, logic [4:0] win);
        want = w;
        lag = l;
        repeat (l + 3) @(negedge ref_clk);
        check("pending", {12'h0, pend}, {12'h0, level_pending});
        check("winner", {11'h0, win}, {11'h0, level_winner[2]});
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) bus_rd(5'(i), 16'h0000);
        foreach (rows[i]) begin
            bus_wr(rows[i].a, rows[i].wd);
            bus_rd(rows[i].a, rows[i].rd);
            check("level", {14'h0, rows[i].lv}, {14'h0, src_level[rows[i].s]});
            check("enabled", 16'h0001, {15'h0, src_enabled[rows[i].s]});
        end
        $display("test rows done");
        bus_wr(5'h05, 16'hffff);
        bus_rd(5'h05, 16'h0000);
        $display("test unmapped done");
        lvl_case(19'h10c00, 0, 4'h4, 5'h0a);
        lvl_case(19'h10800, 2, 4'h4, 5'h0b);
        lvl_case(19'h00020, 0, 4'h0, 5'h00);
        $display("test encoder done");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        check("enabled after reset", 16'h0000, src_enabled[15:0]);
        check("upper enabled after reset", 16'h0000, {13'h0, src_enabled[18:16]});
        bus_rd(5'h03, 16'h0000);
        $display("test reset done");
        print_verdict();
    end
endmodule
